// ==== common/usrw_pkg.sv ====
// package for the usb suspend / resume / remote wake-up block
// assumes a 40 MHz device clock and a byte-wide register port
package usrw_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned IDLE_SUSP_US   = 5000;   // idle time before suspend, us
    localparam int unsigned RESUME_MIN_US  = 1000;   // least k-state tail, us
    localparam int unsigned IDLE_SUSP_CYC  = (IDLE_SUSP_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESUME_MIN_CYC = (RESUME_MIN_US * (CLK_HZ / 1_000_000));

    // register map, byte addresses
    localparam logic [7:0] ADDR_STATUS   = 8'h00; // bus status: flags
    localparam logic [7:0] ADDR_CONTROL  = 8'h04; // bus control: wake request
    localparam logic [7:0] ADDR_PWRCTL   = 8'h08; // cpu power control
    localparam logic [7:0] ADDR_VECTOR   = 8'h0c; // interrupt vector
    localparam logic [7:0] ADDR_P3MASK   = 8'h10; // port three wake mask
    localparam logic [7:0] ADDR_IRQCTL   = 8'h14; // external irq enable

    // field positions
    localparam int unsigned STS_SUSPEND_REQUEST_FLAG_BIT = 0;     // suspend_request_flag
    localparam int unsigned STS_RESUME_REQUEST_FLAG_BIT = 1;     // resume_request_flag
    localparam int unsigned STS_SUSP_BIT = 2;     // clocks stopped
    localparam int unsigned STS_WAKE_BIT = 3;     // wake-up flip-flop
    localparam int unsigned STS_KDRV_BIT = 4;     // k state being driven
    localparam int unsigned CTL_WAKE_REQUEST_BIT_BIT = 0;     // wake_request_bit
    localparam int unsigned PWR_IDL_BIT  = 0;     // idle_mode_bit
    localparam int unsigned IRQ_EN_BIT   = 0;     // external_irq_enable
    localparam int unsigned XIRQ_P3_BIT  = 2;     // irq pin stands in for port bit 2

    // vectors and reset values
    localparam logic [7:0] VEC_NONE      = 8'h00;
    localparam logic [7:0] VEC_SUSPEND   = 8'h16;
    localparam logic [7:0] VEC_RESUME    = 8'h18;
    localparam logic [7:0] VEC_EXTIRQ    = 8'h1f;
    localparam logic [7:0] P3MASK_RST    = 8'hff;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } usrw_req_t;

    // upstream k-state sequencer
    typedef enum logic [1:0] {
        USRW_K_IDLE  = 2'b00,
        USRW_K_PULSE = 2'b01,
        USRW_K_TAIL  = 2'b10
    } usrw_kst_t;

endpackage : usrw_pkg

// ==== rtl/usrw_core.sv ====
// suspend, resume and remote wake-up logic of a full-speed usb function
// assumes line state already decoded to mclk, synchronous inputs, and a cpu
// on a byte register port with read data one cycle after the read strobe
//
// What this block does
// - after 5 ms of unbroken bus idle, declare suspend and interrupt cpu
// - suspend detection sets suspend request flag, which raises its interrupt
// - setting idle mode bit 0 of power control stops all clocks, cpu halts
// - any write to vector register showing 0x16 clears suspend request flag
// - non-idle bus while suspended restarts clocks and raises resume request
// - resume interrupt clears idle mode bit automatically
// - vector write during resume service clears resume request flag
// - wake request bit pulsed 1 then 0 makes the device drive k upstream
// - k signalling lasts wake pulse plus 1 ms
// - unmasked port three falling edge, ored and gated by suspend, is wake-up
// - rising wake term sets flip-flop that leaves suspend, restarts clocks
// - during suspend the external irq pin acts as port three bit 2
// - wake-up reaches cpu interrupt 0 only when external irq enable set
// - wake-up interrupt reports vector 0x1f like the external interrupt
// - external irq during suspend ignored while port bit 2 mask is set
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module usrw_core
    import usrw_pkg::*;
#(
    parameter int unsigned IDLE_CYC   = IDLE_SUSP_CYC,
    parameter int unsigned RESUME_CYC = RESUME_MIN_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // usb line
    input  wire logic        bus_idle_j,
    output logic             k_drive,
    // port three and external irq pin (active low)
    input  wire logic [7:0]  port_three,
    input  wire logic        external_irq_pin_n,
    // cpu side
    output logic             susp_irq,
    output logic             resm_irq,
    output logic             int0_req,
    output logic             clk_run,
    output logic             cpu_halt
);

    usrw_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // registers
    logic [22:0] idle_cnt_q;
    logic [22:0] k_cnt_q;
    logic        suspend_request_flag_q, resume_request_flag_q, idl_q, susp_q, wake_ff_q, wake_request_bit_q, xen_q;
    logic        wterm_q, xirq_q, xirq_sync_q, xirq_dly_q, run_q;
    logic [7:0]  mask_q, vec_q, rdata_q;
    usrw_kst_t   kst_q;
    logic        k_drive_q, int0_q;

    function automatic logic hit(input usrw_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : hit

    // decode
    wire wr_control = hit(req, ADDR_CONTROL);
    wire wr_pwr     = hit(req, ADDR_PWRCTL);
    wire wr_vector  = hit(req, ADDR_VECTOR);
    wire wr_mask    = hit(req, ADDR_P3MASK);
    wire wr_irq     = hit(req, ADDR_IRQCTL);

    // idle detection: count only while awake, the counter is cleared while the clocks are stopped;
    // it parks one past the match so suspend is flagged once and a vector write sticks
    wire idle_full   = (idle_cnt_q >= 23'(IDLE_CYC));
    wire susp_detect = bus_idle_j && (idle_cnt_q == 23'(IDLE_CYC - 1));
    wire bus_active  = !bus_idle_j;

    // wake-up term: pin replaces port bit 2 only while suspended
    logic [7:0] p3_eff;
    always_comb begin
        p3_eff = port_three;
        if (susp_q)
            p3_eff[XIRQ_P3_BIT] = external_irq_pin_n;
    end
    wire wake_term  = susp_q && |(~p3_eff & ~mask_q);         // low inputs, unmasked
    wire wake_rise  = wake_term && !wterm_q;
    wire resume_ev  = susp_q && bus_active;
    wire leave_susp = susp_q && (resume_ev || wake_ff_q);

    // vector clears, set wins over clear
    wire clr_suspend_request_flag = wr_vector && (vec_q == VEC_SUSPEND);
    wire clr_resume_request_flag = wr_vector && (vec_q == VEC_RESUME);

    // external irq synchroniser only moves while clocks run; masked pin is lost
    // pin fall is taken behind the second stage, never from the first one
    wire xirq_fall = xirq_dly_q && !xirq_sync_q && !susp_q;
    wire int0_d    = xen_q && (xirq_fall || wake_rise);

    // vector: highest priority pending source
    logic [7:0] vec_d;
    always_comb begin
        if (suspend_request_flag_q)
            vec_d = VEC_SUSPEND;
        else if (resume_request_flag_q)
            vec_d = VEC_RESUME;
        else if (int0_q)
            vec_d = VEC_EXTIRQ;
        else
            vec_d = VEC_NONE;
    end

    // read mux
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        unique case (req.addr)
            ADDR_STATUS:  rdata_d = {3'h0, k_drive_q, wake_ff_q, susp_q, resume_request_flag_q, suspend_request_flag_q};
            ADDR_CONTROL: rdata_d = {7'h00, wake_request_bit_q};
            ADDR_PWRCTL:  rdata_d = {7'h00, idl_q};
            ADDR_VECTOR:  rdata_d = vec_q;
            ADDR_P3MASK:  rdata_d = mask_q;
            ADDR_IRQCTL:  rdata_d = {7'h00, xen_q};
            default:      rdata_d = 8'h00;
        endcase
        if (!req.rd)
            rdata_d = 8'h00;
    end

    // k-state sequencer: k during the pulse, then a fixed tail
    usrw_kst_t kst_d;
    logic [22:0] k_cnt_d;
    always_comb begin
        kst_d   = kst_q;
        k_cnt_d = k_cnt_q;
        unique case (kst_q)
            USRW_K_IDLE: if (wake_request_bit_q) begin
                kst_d = USRW_K_PULSE;
            end
            USRW_K_PULSE: if (!wake_request_bit_q) begin
                kst_d   = USRW_K_TAIL;
                k_cnt_d = 23'h0;
            end
            USRW_K_TAIL: begin
                k_cnt_d = k_cnt_q + 23'h1;
                if (k_cnt_q == 23'(RESUME_CYC - 1))
                    kst_d = USRW_K_IDLE;                       // pulse plus 1 ms
            end
            default: kst_d = USRW_K_IDLE;
        endcase
    end

    // idle counter
    always_ff @(posedge mclk) begin
        if (srst || bus_active || susp_q)
            idle_cnt_q <= 23'h0;
        else if (!idle_full)
            idle_cnt_q <= idle_cnt_q + 23'h1;
    end

    // request flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            suspend_request_flag_q <= 1'b0;
            resume_request_flag_q <= 1'b0;
        end else begin
            suspend_request_flag_q <= susp_detect | (suspend_request_flag_q & ~clr_suspend_request_flag);
            resume_request_flag_q <= resume_ev | (resume_request_flag_q & ~clr_resume_request_flag);
        end
    end

    // idle mode and suspended state; clocks stop when idle bit is set
    always_ff @(posedge mclk) begin
        if (srst) begin
            idl_q  <= 1'b0;
            susp_q <= 1'b0;
            run_q  <= 1'b1;
        end else begin
            if (resume_ev)
                idl_q <= 1'b0;
            else if (wr_pwr)
                idl_q <= req.wdata[PWR_IDL_BIT];
            if (leave_susp) begin
                susp_q <= 1'b0;
                run_q  <= 1'b1;
            end else if (wr_pwr && req.wdata[PWR_IDL_BIT]) begin
                susp_q <= 1'b1;
                run_q  <= 1'b0;
            end
        end
    end

    // wake-up flip-flop, cleared once suspend is left
    always_ff @(posedge mclk) begin
        if (srst || !susp_q)
            wake_ff_q <= 1'b0;
        else if (wake_rise)
            wake_ff_q <= 1'b1;
        wterm_q <= srst ? 1'b0 : wake_term;
    end

    // control registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            wake_request_bit_q <= 1'b0;
            xen_q  <= 1'b0;
            mask_q <= P3MASK_RST;
        end else begin
            if (wr_control)
                wake_request_bit_q <= req.wdata[CTL_WAKE_REQUEST_BIT_BIT];
            if (wr_irq)
                xen_q <= req.wdata[IRQ_EN_BIT];
            if (wr_mask)
                mask_q <= req.wdata;
        end
    end

    // external irq synchroniser, held while clocks are stopped
    always_ff @(posedge mclk) begin
        if (srst) begin
            xirq_q      <= 1'b1;
            xirq_sync_q <= 1'b1;
            xirq_dly_q  <= 1'b1;
        end else if (!susp_q) begin
            xirq_q      <= external_irq_pin_n;
            xirq_sync_q <= xirq_q;
            xirq_dly_q  <= xirq_sync_q;
        end
    end

    // sequencer, vector, outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            kst_q     <= USRW_K_IDLE;
            k_cnt_q   <= 23'h0;
            vec_q     <= VEC_NONE;
            rdata_q   <= 8'h00;
            k_drive_q <= 1'b0;
            int0_q    <= 1'b0;
        end else begin
            kst_q     <= kst_d;
            k_cnt_q   <= k_cnt_d;
            vec_q     <= vec_d;
            rdata_q   <= rdata_d;
            k_drive_q <= (kst_d != USRW_K_IDLE);
            int0_q    <= int0_d | (int0_q & ~(wr_vector && vec_q == VEC_EXTIRQ));
        end
    end

    assign reg_rdata = rdata_q;
    assign k_drive   = k_drive_q;
    assign susp_irq  = suspend_request_flag_q;
    assign resm_irq  = resume_request_flag_q;
    assign int0_req  = int0_q;
    assign clk_run   = run_q;
    assign cpu_halt  = idl_q;

endmodule : usrw_core

// ==== verification/tb_top.sv ====
// self-checking bench for the suspend / resume / wake-up core
// assumes short idle and tail counts set through parameters
`timescale 1ns/1ps

module tb_top;
    import usrw_pkg::*;
    localparam int unsigned IC = 50;
    localparam int unsigned RC = 20;
    logic       mclk, srst, reg_wr, reg_rd, quiet, bus_idle_j, external_irq_pin_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_three, rv;
    logic       k_drive, susp_irq, resm_irq, int0_req, clk_run, cpu_halt;
    int         errors, num_checks, n;
    int         cyc = 0;

    usrw_core #(.IDLE_CYC(IC), .RESUME_CYC(RC)) i_dut (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_idle_j(bus_idle_j), .k_drive(k_drive), .port_three(port_three),
        .external_irq_pin_n(external_irq_pin_n), .susp_irq(susp_irq),
        .resm_irq(resm_irq), .int0_req(int0_req), .clk_run(clk_run), .cpu_halt(cpu_halt));
    usrw_host_model i_host (.mclk(mclk), .quiet(quiet), .k_drive(k_drive),
        .bus_idle_j(bus_idle_j));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe, so sample mid-cycle
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    function logic sel(input int s);
        case (s)
            0: return susp_irq;
            1: return resm_irq;
            2: return k_drive;
            default: return clk_run;
        endcase
    endfunction : sel

    // bounded wait, returns the cycles taken
    task wt(input int s, output int c);
        c = 0;
        @(negedge mclk);
        while (sel(s) !== 1'b1 && c < 400) begin
            @(negedge mclk);
            c++;
        end
    endtask : wt

    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        quiet = 1'b0; port_three = 8'hff; external_irq_pin_n = 1'b1;
        errors = 0; num_checks = 0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rd(ADDR_STATUS, rv); chk(rv, 8'h00);
        rd(ADDR_P3MASK, rv); chk(rv, P3MASK_RST);
        rd(8'h3c, rv); chk(rv, 8'h00);
        chk({7'h00, clk_run}, 8'h01);
        $display("test reset done");
        // ordinary pin interrupt while awake, first with the enable clear, then set
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk); external_irq_pin_n <= 1'b0;
            repeat (5) @(negedge mclk);
            chk({7'h00, int0_req}, 8'(i));
            @(posedge mclk); external_irq_pin_n <= 1'b1;
            wr(ADDR_IRQCTL, 8'h01);
        end
        rd(ADDR_VECTOR, rv); chk(rv, VEC_EXTIRQ);
        wr(ADDR_VECTOR, 8'h00); @(negedge mclk); chk({7'h00, int0_req}, 8'h00);
        @(posedge mclk); quiet <= 1'b1;
        wt(0, n); chk(8'(n >= IC && n <= IC + 4), 8'h01);
        rd(ADDR_VECTOR, rv); chk(rv, VEC_SUSPEND);
        wr(ADDR_VECTOR, 8'h5a); @(negedge mclk); chk({7'h00, susp_irq}, 8'h00);
        wr(ADDR_PWRCTL, 8'h01); @(negedge mclk); chk({6'h00, cpu_halt, clk_run}, 8'h02);
        @(posedge mclk); quiet <= 1'b0;
        wt(1, n); chk({6'h00, cpu_halt, clk_run}, 8'h01);
        rd(ADDR_VECTOR, rv); chk(rv, VEC_RESUME);
        wr(ADDR_VECTOR, 8'h00); @(negedge mclk); chk({7'h00, resm_irq}, 8'h00);
        $display("test suspend done");
        wr(ADDR_CONTROL, 8'h01); wt(2, n); chk(8'(n <= 2), 8'h01);
        wr(ADDR_CONTROL, 8'h00);
        n = 0;
        while (k_drive === 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk(8'(n >= RC - 1 && n <= 2 * RC + 2), 8'h01);
        $display("test wake done");
        // pin masked first, then unmasked as port bit 2
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk); quiet <= 1'b1;
            wt(0, n);
            wr(ADDR_VECTOR, 8'h00);
            wr(ADDR_P3MASK, (i == 1) ? 8'hfb : 8'hff);
            wr(ADDR_PWRCTL, 8'h01);
            @(posedge mclk); external_irq_pin_n <= 1'b0;
            repeat (4) @(negedge mclk);
            chk({7'h00, clk_run}, 8'(i));
            chk({7'h00, int0_req}, 8'(i));
            if (i == 1) begin
                rd(ADDR_VECTOR, rv); chk(rv, VEC_EXTIRQ);
                rd(ADDR_STATUS, rv); chk({7'h00, rv[STS_WAKE_BIT]}, 8'h00);
            end
            @(posedge mclk); external_irq_pin_n <= 1'b1; quiet <= 1'b0;
            repeat (4) @(negedge mclk);
            wr(ADDR_VECTOR, 8'h00);
        end
        $display("test port wake done");
        stop_test();
    end
endmodule : tb_top

bind usrw_core usrw_chk #(.IDLE_CYC(IDLE_CYC), .RESUME_CYC(RESUME_CYC)) i_chk (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_idle_j(bus_idle_j),
    .k_drive(k_drive), .port_three(port_three), .external_irq_pin_n(external_irq_pin_n),
    .susp_irq(susp_irq), .resm_irq(resm_irq), .int0_req(int0_req),
    .clk_run(clk_run), .cpu_halt(cpu_halt));

// ==== verification/usrw_chk.sv ====
// checker for the usb suspend / resume / wake-up core
// assumes bind onto usrw_core; watches its ports only
`timescale 1ns/1ps

module usrw_chk
    import usrw_pkg::*;
#(
    parameter int unsigned IDLE_CYC   = IDLE_SUSP_CYC,
    parameter int unsigned RESUME_CYC = RESUME_MIN_CYC
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // usb line and port three
    input wire logic       bus_idle_j,
    input wire logic       k_drive,
    input wire logic [7:0] port_three,
    input wire logic       external_irq_pin_n,
    // cpu side
    input wire logic       susp_irq,
    input wire logic       resm_irq,
    input wire logic       int0_req,
    input wire logic       clk_run,
    input wire logic       cpu_halt
);
    logic [31:0] idle_q;
    logic        en_q;
    logic        wake_request_bit_q;
    // decoded register writes
    wire logic wr_vec = reg_wr && (reg_addr == ADDR_VECTOR);
    wire logic wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
    wire logic wr_pwr = reg_wr && (reg_addr == ADDR_PWRCTL);
    wire logic wr_irq = reg_wr && (reg_addr == ADDR_IRQCTL);

    // idle run length and shadows of the enable and wake bits
    always_ff @(posedge mclk) begin
        if (srst) begin
            idle_q <= '0;
            en_q   <= 1'b0;
            wake_request_bit_q <= 1'b0;
        end else begin
            idle_q <= bus_idle_j ? idle_q + 1 : '0;
            if (wr_irq) en_q <= reg_wdata[IRQ_EN_BIT];
            if (wr_ctl) wake_request_bit_q <= reg_wdata[CTL_WAKE_REQUEST_BIT_BIT];
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    susp_detect_a : assert property ($rose(susp_irq) |-> idle_q >= IDLE_CYC - 1)
        else $error("suspend flag before idle time ran out");
    rdata_zero_a : assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    halt_stop_a : assert property (wr_pwr && reg_wdata[0] |=> cpu_halt && !clk_run)
        else $error("idle bit did not stop clocks");
    bus_resume_a : assert property (!clk_run && !bus_idle_j |=> resm_irq && clk_run && !cpu_halt)
        else $error("bus activity did not resume");
    suspend_request_flag_clear_a : assert property ($fell(susp_irq) && !$past(srst) |-> $past(wr_vec))
        else $error("suspend flag cleared without vector write");
    resume_request_flag_clear_a : assert property ($fell(resm_irq) && !$past(srst) |-> $past(wr_vec))
        else $error("resume flag cleared without vector write");
    kdrive_start_a : assert property (wr_ctl && reg_wdata[0] |-> ##[1:2] k_drive)
        else $error("wake request gave no k state");
    kdrive_hold_a : assert property ($fell(k_drive) && !$past(srst) |-> !wake_request_bit_q)
        else $error("k state ended while wake bit held");
    int0_gate_a : assert property ($rose(int0_req) |-> en_q)
        else $error("interrupt 0 without enable");
endmodule : usrw_chk

// ==== verification/usrw_host_model.sv ====
// upstream host / hub port model for the wake-up core
// assumes the bench says when the host leaves the line quiet
`timescale 1ns/1ps

module usrw_host_model (
    // clock
    input wire logic  mclk,
    // control from the bench
    input wire logic  quiet,
    // usb line
    input wire logic  k_drive,
    output logic      bus_idle_j
);
    // a hub repeats a device k as resume, so the line leaves j then
    always_ff @(posedge mclk) begin
        bus_idle_j <= quiet & ~k_drive;
    end
endmodule : usrw_host_model
